// ===== include/wbo_defines.vh
// constants for the word and bit operation execution unit
// assumes inclusion by bare name from the execution unit design file; the adder does not include it
`ifndef WBO_DEFINES_VH
`define WBO_DEFINES_VH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define WBO_OP_WORD_ADD      8'h1D
`define WBO_OP_WORD_SUBTRACT 8'h3D
`define WBO_OP_WORD_COMPARE  8'h5D
`define WBO_OP_WORD_DEC      8'hBD
`define WBO_OP_WORD_INC      8'h9D
`define WBO_OP_LOAD_PAIR     8'h7D
`define WBO_OP_STORE_PAIR    8'hDD
`define WBO_OP_BIT_AND_C     8'h8B
`define WBO_OP_BIT_OR_C      8'h6B
`define WBO_OP_BIT_XOR_C     8'hAB
`define WBO_OP_LOAD_C        8'hCB
`define WBO_OP_STORE_C       8'hEB
`define WBO_OP_BIT_INVERT    8'h4B
`define WBO_OP_TEST_DP       8'h0C
`define WBO_OP_TEST_ABS      8'h1C
`define WBO_OP_ACC_BIT_CLR   8'h2B
`define WBO_OP_ACC_BIT_SET   8'h0B
`define WBO_OP_CARRY_CLR     8'h20
`define WBO_OP_CARRY_SET     8'hA0
`define WBO_OP_G_CLR         8'h40
`define WBO_OP_G_SET         8'hC0
`define WBO_OP_OVF_CLR       8'h80
`define WBO_OP_TEST_CLR_BITS 8'h5C
`define WBO_OP_TEST_SET_BITS 8'h3C
// low nibble shared by the direct-page bit clear/set families
`define WBO_DBIT_NIBBLE      4'h1

// ----------------------------------------
// cycle counts, start cycle to done cycle
// ----------------------------------------
`define WBO_CYC_WORD_ARITH   3'h5
`define WBO_CYC_WORD_CMP     3'h4
`define WBO_CYC_WORD_RMW     3'h6
`define WBO_CYC_PAIR_MOVE    3'h5
`define WBO_CYC_BIT_AND      3'h4
`define WBO_CYC_BIT_OR_XOR   3'h5
`define WBO_CYC_LOAD_C       3'h4
`define WBO_CYC_STORE_C      3'h6
`define WBO_CYC_BIT_INVERT   3'h5
`define WBO_CYC_TEST_DP      3'h4
`define WBO_CYC_TEST_ABS     3'h5
`define WBO_CYC_DBIT         3'h4
`define WBO_CYC_REG_ONLY     3'h2
`define WBO_CYC_TEST_BITS    3'h6

// ----------------------------------------
// status flag positions and reset values
// ----------------------------------------
`define WBO_F_N 7
`define WBO_F_V 6
`define WBO_F_G 5
`define WBO_F_H 3
`define WBO_F_Z 1
`define WBO_F_C 0
`define WBO_RST_BYTE 8'h00
`define WBO_RST_ADDR 16'h0000

`endif

// ===== logic/wbo_alu.v
// 16-bit adder/subtractor with status flags for the word operations
// assumes purely combinational use by the execution unit
`timescale 1ns/10ps
`default_nettype none
module wbo_alu (
  input  wire [15:0] op_a,   // minuend or first addend
  input  wire [15:0] op_b,   // subtrahend or second addend
  input  wire        sub,    // 1 = subtract
  output wire [15:0] res,    // result
  output wire        fl_n,   // sign of result
  output wire        fl_v,   // signed overflow
  output wire        fl_h,   // carry out of bit 11
  output wire        fl_z,   // result zero
  output wire        fl_c    // carry out; on subtract 1 means no borrow
);
  // subtract as a + ~b + 1 so one carry chain serves both
  wire [15:0] b_eff = sub ? ~op_b : op_b;
  wire [16:0] sum   = {1'b0, op_a} + {1'b0, b_eff} + {16'h0000, sub};
  wire [12:0] low   = {1'b0, op_a[11:0]} + {1'b0, b_eff[11:0]} + {12'h000, sub};

  assign res  = sum[15:0];
  assign fl_n = sum[15];
  assign fl_v = (op_a[15] == b_eff[15]) && (sum[15] != op_a[15]);
  assign fl_h = low[12];
  assign fl_z = (sum[15:0] == 16'h0000);
  assign fl_c = sum[16];
endmodule // wbo_alu
`default_nettype wire

// ===== logic/wbo_exec.v
// execution unit for the word operations and bit manipulation group
// assumes a fetch unit that hands over opcode and operand bytes with a
// one-cycle start pulse, and a data memory that returns read data in the
// cycle after mem_rd is high and takes writes at the edge ending mem_wr
//
// Functional notes
// RULE1: word add: pair plus memory pair, no carry in, sets N V H Z C
// RULE2: word subtract: pair minus memory pair, no borrow in, sets N V H Z C
// RULE3: word compare: pair minus memory pair, only N Z C change
// RULE4: word decrement: memory pair minus one written back, sets N Z
// RULE5: word increment: memory pair plus one written back, sets N Z
// RULE6: load pair from memory pair, high byte from next address, sets N Z
// RULE7: store accumulator at address, Y at next address, flags kept
// RULE8: carry becomes carry AND bit, or AND inverted bit
// RULE9: carry becomes carry OR bit, or OR inverted bit
// RULE10: carry becomes carry XOR bit, or XOR inverted bit
// RULE11: carry loaded from bit or from inverted bit
// RULE12: carry stored into addressed bit, other bits and flags kept
// RULE13: addressed memory bit inverted by read-modify-write, flags kept
// RULE14: bit test: Z from A AND M, N from M7, V from M6, no write
// RULE15: direct-page bit forced low or high, other bits and flags kept
// RULE16: accumulator bit forced low or high, flags kept
// RULE17: carry forced low or high
// RULE18: G flag forced low or high
// RULE19: overflow flag forced low
// RULE20: N Z from A minus M, then M written as M AND NOT A
// RULE21: N Z from A minus M, then M written as M OR A
// RULE22: operand bytes carry variant, bit number and address for bit ops
// RULE23: x/y families take bit number from opcode top bits
`timescale 1ns/10ps
`default_nettype none
`include "wbo_defines.vh"
module wbo_exec #(
  parameter AW = 16                 // data memory address width
) (
  input  wire          clock,       // core clock
  input  wire          nrst,        // asynchronous reset, active low
  input  wire          start,       // one-cycle request, taken when idle
  input  wire [7:0]    opcode,      // instruction opcode
  input  wire [7:0]    oper1,       // first operand byte
  input  wire [7:0]    oper2,       // second operand byte
  input  wire [7:0]    a_in,        // accumulator at start
  input  wire [7:0]    y_in,        // Y register at start
  input  wire [7:0]    psw_in,      // status flags at start
  input  wire [7:0]    mem_rdata,   // memory read data
  output reg           busy,        // instruction in progress
  output reg           done,        // one-cycle pulse, results valid
  output reg           bad_op,      // opcode not handled by this unit
  output reg  [7:0]    a_out,       // accumulator result
  output reg  [7:0]    y_out,       // Y register result
  output reg  [7:0]    psw_out,     // status flag result
  output reg  [AW-1:0] mem_addr,    // memory address
  output reg           mem_rd,      // memory read strobe
  output reg           mem_wr,      // memory write strobe
  output reg  [7:0]    mem_wdata    // memory write data
);

  // ----------------------------------------
  // instruction classes
  // ----------------------------------------
  localparam [3:0] CL_NONE = 4'h0;
  localparam [3:0] CL_WRD  = 4'h1;  // word read into pair or flags
  localparam [3:0] CL_WRMW = 4'h2;  // word read-modify-write
  localparam [3:0] CL_WST  = 4'h3;  // pair store
  localparam [3:0] CL_MBIT = 4'h4;  // 3-byte memory bit ops
  localparam [3:0] CL_DBIT = 4'h5;  // direct-page bit clear/set
  localparam [3:0] CL_BIT  = 4'h6;  // bit test
  localparam [3:0] CL_TST  = 4'h7;  // test and set/clear bits
  localparam [3:0] CL_REG  = 4'h8;  // register and flag only

  // ----------------------------------------
  // decode of the incoming request
  // ----------------------------------------
  reg [3:0]    cls_d;
  reg [2:0]    ncyc_d;
  reg [AW-1:0] ea_d;
  reg [2:0]    bitn_d;

  wire [AW-1:0] dp_addr  = {{(AW-9){1'b0}}, psw_in[`WBO_F_G], oper1};
  // padded first and then cut, so no zero-width replication at AW=16
  wire [AW+15:0] abs_ext = {{AW{1'b0}}, oper2, oper1};
  wire [AW-1:0]  abs_addr = abs_ext[AW-1:0];
  // 3-byte bit form: variant in top bit, then bit number, then 12-bit address
  wire [AW-1:0] mb_addr  = {{(AW-12){1'b0}}, oper2[3:0], oper1};

  always @* begin
    cls_d  = CL_NONE;
    ncyc_d = `WBO_CYC_REG_ONLY;
    ea_d   = dp_addr;
    bitn_d = oper1[2:0];
    case (opcode)
      `WBO_OP_WORD_ADD, `WBO_OP_WORD_SUBTRACT: begin
        cls_d  = CL_WRD;
        ncyc_d = `WBO_CYC_WORD_ARITH;
      end
      `WBO_OP_WORD_COMPARE: begin
        cls_d  = CL_WRD;
        ncyc_d = `WBO_CYC_WORD_CMP;
      end
      `WBO_OP_LOAD_PAIR: begin
        cls_d  = CL_WRD;
        ncyc_d = `WBO_CYC_PAIR_MOVE;
      end
      `WBO_OP_WORD_DEC, `WBO_OP_WORD_INC: begin
        cls_d  = CL_WRMW;
        ncyc_d = `WBO_CYC_WORD_RMW;
      end
      `WBO_OP_STORE_PAIR: begin
        cls_d  = CL_WST;
        ncyc_d = `WBO_CYC_PAIR_MOVE;
      end
      `WBO_OP_BIT_AND_C, `WBO_OP_LOAD_C: begin
        cls_d  = CL_MBIT;
        ncyc_d = `WBO_CYC_BIT_AND;
      end
      `WBO_OP_BIT_OR_C, `WBO_OP_BIT_XOR_C: begin
        cls_d  = CL_MBIT;
        ncyc_d = `WBO_CYC_BIT_OR_XOR;
      end
      `WBO_OP_STORE_C: begin
        cls_d  = CL_MBIT;
        ncyc_d = `WBO_CYC_STORE_C;
      end
      `WBO_OP_BIT_INVERT: begin
        cls_d  = CL_MBIT;
        ncyc_d = `WBO_CYC_BIT_INVERT;
      end
      `WBO_OP_TEST_DP: begin
        cls_d  = CL_BIT;
        ncyc_d = `WBO_CYC_TEST_DP;
      end
      `WBO_OP_TEST_ABS: begin
        cls_d  = CL_BIT;
        ncyc_d = `WBO_CYC_TEST_ABS;
      end
      `WBO_OP_TEST_CLR_BITS, `WBO_OP_TEST_SET_BITS: begin
        cls_d  = CL_TST;
        ncyc_d = `WBO_CYC_TEST_BITS;
      end
      `WBO_OP_ACC_BIT_CLR, `WBO_OP_ACC_BIT_SET, `WBO_OP_CARRY_CLR,
      `WBO_OP_CARRY_SET, `WBO_OP_G_CLR, `WBO_OP_G_SET, `WBO_OP_OVF_CLR: begin
        cls_d  = CL_REG;
      end
      default: begin
        // RULE23: family bit number
        if (opcode[3:0] == `WBO_DBIT_NIBBLE) begin
          cls_d  = CL_DBIT;
          ncyc_d = `WBO_CYC_DBIT;
          bitn_d = opcode[7:5];
        end
      end
    endcase
    if (cls_d == CL_TST || opcode == `WBO_OP_TEST_ABS)
      ea_d = abs_addr;
    // RULE22: operand byte fields
    if (cls_d == CL_MBIT) begin
      ea_d   = mb_addr;
      bitn_d = oper2[6:4];
    end
  end

  // ----------------------------------------
  // held instruction state
  // ----------------------------------------
  reg [7:0]    op_reg;
  reg [3:0]    cls_reg;
  reg [2:0]    ncyc_reg;
  reg [2:0]    step_reg;
  reg [AW-1:0] ea_reg;
  reg [2:0]    bitn_reg;
  reg          inv_reg;
  reg [7:0]    lo_reg;
  reg [15:0]   res_reg;

  // one-hot mask of the selected bit
  wire [7:0] mask;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
      localparam [2:0] IDX = gi;
      assign mask[gi] = (bitn_reg == IDX);
    end
  endgenerate

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  wire [15:0] mem_pair = {mem_rdata, lo_reg};
  wire        is_rmw   = (cls_reg == CL_WRMW);
  wire        is_sub   = (op_reg == `WBO_OP_WORD_SUBTRACT) ||
                         (op_reg == `WBO_OP_WORD_COMPARE) ||
                         (op_reg == `WBO_OP_WORD_DEC);
  wire [15:0] alu_a    = is_rmw ? mem_pair : {y_out, a_out};
  wire [15:0] alu_b    = is_rmw ? 16'h0001 : mem_pair;
  wire [15:0] alu_res;
  wire        alu_n;
  wire        alu_v;
  wire        alu_h;
  wire        alu_z;
  wire        alu_c;

  wbo_alu u_alu (
    .op_a (alu_a),
    .op_b (alu_b),
    .sub  (is_sub),
    .res  (alu_res),
    .fl_n (alu_n),
    .fl_v (alu_v),
    .fl_h (alu_h),
    .fl_z (alu_z),
    .fl_c (alu_c)
  );

  wire       m_bit  = |(mem_rdata & mask);
  wire       m_sel  = m_bit ^ inv_reg;
  wire       c_now  = psw_out[`WBO_F_C];
  wire [7:0] a_diff = a_out - mem_rdata;
  wire       last   = (step_reg == ncyc_reg - 3'h1);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      bad_op    <= 1'b0;
      a_out     <= `WBO_RST_BYTE;
      y_out     <= `WBO_RST_BYTE;
      psw_out   <= `WBO_RST_BYTE;
      mem_addr  <= {AW{1'b0}};
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_wdata <= `WBO_RST_BYTE;
      op_reg    <= `WBO_RST_BYTE;
      cls_reg   <= CL_NONE;
      ncyc_reg  <= `WBO_CYC_REG_ONLY;
      step_reg  <= 3'h0;
      ea_reg    <= {AW{1'b0}};
      bitn_reg  <= 3'h0;
      inv_reg   <= 1'b0;
      lo_reg    <= `WBO_RST_BYTE;
      res_reg   <= 16'h0000;
    end else begin
      done   <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy     <= 1'b1;
          bad_op   <= (cls_d == CL_NONE);
          op_reg   <= opcode;
          cls_reg  <= cls_d;
          ncyc_reg <= ncyc_d;
          step_reg <= 3'h1;
          ea_reg   <= ea_d;
          bitn_reg <= bitn_d;
          inv_reg  <= oper2[7];
          a_out    <= a_in;
          y_out    <= y_in;
          psw_out  <= psw_in;
          mem_addr <= ea_d;
          // RULE7: accumulator to low address
          if (cls_d == CL_WST) begin
            mem_wr    <= 1'b1;
            mem_wdata <= a_in;
          end else if (cls_d != CL_REG && cls_d != CL_NONE) begin
            mem_rd <= 1'b1;
          end
        end
      end else begin
        step_reg <= step_reg + 3'h1;
        if (last) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        case (cls_reg)
          CL_WRD, CL_WRMW: begin
            // high byte sits at the following address
            if (step_reg == 3'h1) begin
              mem_rd   <= 1'b1;
              mem_addr <= ea_reg + 1'b1;
            end
            if (step_reg == 3'h2)
              lo_reg <= mem_rdata;
            if (step_reg == 3'h3) begin
              case (op_reg)
                // RULE1: word add
                // RULE2: word subtract
                `WBO_OP_WORD_ADD, `WBO_OP_WORD_SUBTRACT: begin
                  {y_out, a_out}      <= alu_res;
                  psw_out[`WBO_F_N]   <= alu_n;
                  psw_out[`WBO_F_V]   <= alu_v;
                  psw_out[`WBO_F_H]   <= alu_h;
                  psw_out[`WBO_F_Z]   <= alu_z;
                  psw_out[`WBO_F_C]   <= alu_c;
                end
                // RULE3: compare, flags only
                `WBO_OP_WORD_COMPARE: begin
                  psw_out[`WBO_F_N] <= alu_n;
                  psw_out[`WBO_F_Z] <= alu_z;
                  psw_out[`WBO_F_C] <= alu_c;
                end
                // RULE6: load pair
                `WBO_OP_LOAD_PAIR: begin
                  {y_out, a_out}    <= mem_pair;
                  psw_out[`WBO_F_N] <= mem_pair[15];
                  psw_out[`WBO_F_Z] <= (mem_pair == 16'h0000);
                end
                // RULE4: decrement written back
                // RULE5: increment written back
                default: begin
                  res_reg           <= alu_res;
                  psw_out[`WBO_F_N] <= alu_n;
                  psw_out[`WBO_F_Z] <= alu_z;
                  mem_wr            <= 1'b1;
                  mem_addr          <= ea_reg;
                  mem_wdata         <= alu_res[7:0];
                end
              endcase
            end
            if (is_rmw && step_reg == 3'h4) begin
              mem_wr    <= 1'b1;
              mem_addr  <= ea_reg + 1'b1;
              mem_wdata <= res_reg[15:8];
            end
          end
          CL_WST: begin
            // RULE7: Y to high address
            if (step_reg == 3'h1) begin
              mem_wr    <= 1'b1;
              mem_addr  <= ea_reg + 1'b1;
              mem_wdata <= y_out;
            end
          end
          CL_MBIT, CL_DBIT, CL_BIT, CL_TST: begin
            // byte read at start arrives here; writes go to the same address
            if (step_reg == 3'h2) begin
              mem_addr <= ea_reg;
              case (op_reg)
                // RULE8: carry AND bit
                `WBO_OP_BIT_AND_C: psw_out[`WBO_F_C] <= c_now & m_sel;
                // RULE9: carry OR bit
                `WBO_OP_BIT_OR_C:  psw_out[`WBO_F_C] <= c_now | m_sel;
                // RULE10: carry XOR bit
                `WBO_OP_BIT_XOR_C: psw_out[`WBO_F_C] <= c_now ^ m_sel;
                // RULE11: carry from bit
                `WBO_OP_LOAD_C:    psw_out[`WBO_F_C] <= m_sel;
                // RULE12: carry into bit
                `WBO_OP_STORE_C: begin
                  mem_wr    <= 1'b1;
                  mem_wdata <= (mem_rdata & ~mask) | (c_now ? mask : 8'h00);
                end
                // RULE13: invert bit
                `WBO_OP_BIT_INVERT: begin
                  mem_wr    <= 1'b1;
                  mem_wdata <= mem_rdata ^ mask;
                end
                // RULE14: bit test flags
                `WBO_OP_TEST_DP, `WBO_OP_TEST_ABS: begin
                  psw_out[`WBO_F_Z] <= ((a_out & mem_rdata) == 8'h00);
                  psw_out[`WBO_F_N] <= mem_rdata[7];
                  psw_out[`WBO_F_V] <= mem_rdata[6];
                end
                // RULE20: test and clear
                `WBO_OP_TEST_CLR_BITS: begin
                  psw_out[`WBO_F_N] <= a_diff[7];
                  psw_out[`WBO_F_Z] <= (a_diff == 8'h00);
                  mem_wr            <= 1'b1;
                  mem_wdata         <= mem_rdata & ~a_out;
                end
                // RULE21: test and set
                `WBO_OP_TEST_SET_BITS: begin
                  psw_out[`WBO_F_N] <= a_diff[7];
                  psw_out[`WBO_F_Z] <= (a_diff == 8'h00);
                  mem_wr            <= 1'b1;
                  mem_wdata         <= mem_rdata | a_out;
                end
                // RULE15: force memory bit
                default: begin
                  mem_wr    <= 1'b1;
                  mem_wdata <= op_reg[4] ? (mem_rdata & ~mask) : (mem_rdata | mask);
                end
              endcase
            end
          end
          CL_REG: begin
            if (step_reg == 3'h1) begin
              case (op_reg)
                // RULE16: accumulator bit
                `WBO_OP_ACC_BIT_CLR: a_out <= a_out & ~mask;
                `WBO_OP_ACC_BIT_SET: a_out <= a_out | mask;
                // RULE17: carry clear/set
                `WBO_OP_CARRY_CLR:   psw_out[`WBO_F_C] <= 1'b0;
                `WBO_OP_CARRY_SET:   psw_out[`WBO_F_C] <= 1'b1;
                // RULE18: G clear/set
                `WBO_OP_G_CLR:       psw_out[`WBO_F_G] <= 1'b0;
                `WBO_OP_G_SET:       psw_out[`WBO_F_G] <= 1'b1;
                // RULE19: overflow clear
                `WBO_OP_OVF_CLR:     psw_out[`WBO_F_V] <= 1'b0;
                default:             psw_out <= psw_out;
              endcase
            end
          end
          default: begin
            // unknown opcode: runs the short count with no effect
            lo_reg <= lo_reg;
          end
        endcase
      end
    end
  end

endmodule // wbo_exec
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the word and bit execution unit
// assumes the memory model as far side and the monitor bound to the unit
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clock, nrst, start;
  logic [7:0]  opcode, oper1, oper2, a_in, y_in, psw_in;
  wire  [7:0]  mem_rdata, a_out, y_out, psw_out, mem_wdata;
  wire  [15:0] mem_addr;
  wire         busy, done, bad_op, mem_rd, mem_wr;
  logic [56:0] expq [$];
  logic [56:0] e;
  integer      mismatches, comparisons, i;
  localparam [191:0] OPS = {8'h1D, 8'h3D, 8'h5D, 8'hBD, 8'h9D, 8'h7D, 8'hDD, 8'h8B,
    8'h6B, 8'hAB, 8'hCB, 8'hEB, 8'h4B, 8'h0C, 8'h1C, 8'h2B, 8'h0B, 8'h20, 8'hA0,
    8'h40, 8'hC0, 8'h80, 8'h5C, 8'h3C};
  wbo_exec #(.AW(16)) dut (.clock(clock), .nrst(nrst), .start(start), .opcode(opcode),
    .oper1(oper1), .oper2(oper2), .a_in(a_in), .y_in(y_in), .psw_in(psw_in),
    .mem_rdata(mem_rdata), .busy(busy), .done(done), .bad_op(bad_op), .a_out(a_out),
    .y_out(y_out), .psw_out(psw_out), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata));
  wbo_mem_model far (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    begin
      comparisons = comparisons + 1;
      if (seen !== want) begin
        mismatches = mismatches + 1;
        $display("[ERR] %s expected %0h seen %0h", what, want, seen);
      end
    end
  endtask
  task results;
    begin
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ----------------------------------------
  // driver: one instruction, expected result queued
  // ----------------------------------------
  // fm[16] forces the memory pair; poke retries start while busy
  task automatic run(input logic [7:0] op, input logic [16:0] fm, input bit poke);
    logic [15:0] ea, m, r;
    logic [16:0] s;
    logic [12:0] h;
    logic [7:0]  a, y, p, m0, m1, o1, o2;
    logic        bt, bad;
    integer      n, k;
    begin
      #1;
      {o1, o2, a, y, p} = {$urandom, $urandom};
      ea = {7'h00, p[5], o1};
      if (op == 8'h1C || op == 8'h5C || op == 8'h3C) ea = {o2, o1};
      if (op[3:0] == 4'hB) ea = {4'h0, o2[3:0], o1};
      m = fm[16] ? fm[15:0] : 16'($urandom);
      far.mem[ea] = m[7:0];
      far.mem[ea + 16'h1] = m[15:8];
      {opcode, oper1, oper2, a_in, y_in, psw_in, start} = {op, o1, o2, a, y, p, 1'b1};
      {m1, m0, bad, n} = {m, 1'b0, 32'd2};
      bt = m0[o2[6:4]] ^ o2[7];
      case (op)
        8'h1D, 8'h3D, 8'h5D: begin
          r = (op == 8'h1D) ? m : ~m;
          s = {1'b0, y, a} + r + (op != 8'h1D);
          h = {1'b0, y[3:0], a} + r[11:0] + (op != 8'h1D);
          {p[7], p[1], p[0], n} = {s[15], s[15:0] == 16'h0, s[16], op[6] ? 32'd4 : 32'd5};
          if (op != 8'h5D) {y, a, p[6], p[3]} = {s[15:0], y[7] == r[15] && s[15] != y[7], h[12]};
        end
        8'h9D, 8'hBD: begin
          r = op[5] ? m - 16'h1 : m + 16'h1;
          {m1, m0, p[7], p[1], n} = {r, r[15], r == 16'h0, 32'd6};
        end
        8'h7D: {y, a, p[7], p[1], n} = {m, m[15], m == 16'h0, 32'd5};
        8'hDD: {m1, m0, n} = {y, a, 32'd5};
        8'h8B: {p[0], n} = {p[0] & bt, 32'd4};
        8'h6B: {p[0], n} = {p[0] | bt, 32'd5};
        8'hAB: {p[0], n} = {p[0] ^ bt, 32'd5};
        8'hCB: {p[0], n} = {bt, 32'd4};
        8'hEB: {m0[o2[6:4]], n} = {p[0], 32'd6};
        8'h4B: {m0[o2[6:4]], n} = {~m0[o2[6:4]], 32'd5};
        8'h0C, 8'h1C: {p[7], p[6], p[1], n} = {m0[7], m0[6], (a & m0) == 8'h0, op[4] ? 32'd5 : 32'd4};
        8'h2B, 8'h0B: a[o1[2:0]] = ~op[5];
        8'h20, 8'hA0: p[0] = op[7];
        8'h40, 8'hC0: p[5] = op[7];
        8'h80: p[6] = 1'b0;
        8'h5C, 8'h3C: begin
          r = a - m0;
          {p[7], p[1], n} = {r[7], r[7:0] == 8'h0, 32'd6};
          m0 = op[6] ? m0 & ~a : m0 | a;
        end
        default: if (op[3:0] == 4'h1) {m0[op[7:5]], n} = {~op[4], 32'd4}; else bad = 1'b1;
      endcase
      expq.push_back({ea, a, y, p, m0, m1, bad});
      @(negedge clock);
      start = 1'b0;
      for (k = 1; done !== 1'b1 && k < 12; k = k + 1) begin
        @(negedge clock);
        start = poke && k == 1;
      end
      chk("cycles", k, n);
    end
  endtask
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(negedge clock) begin
    if (done === 1'b1) begin
      e = expq.pop_front();
      chk("a_y", {a_out, y_out}, e[40:25]);
      chk("psw", psw_out, e[24:17]);
      chk("bad_op", bad_op, e[0]);
      chk("mem", {far.mem[e[56:41]], far.mem[e[56:41] + 16'h1]}, e[16:1]);
    end
  end
  initial begin
    {nrst, start, opcode, oper1, oper2, a_in, y_in, psw_in} = 49'h0;
    mismatches = 0;
    comparisons = 0;
    void'($urandom(32'h9496));
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    for (i = 0; i < 96; i = i + 1) run(OPS[(i % 24) * 8 +: 8], 17'h0, 1'b0);
    for (i = 0; i < 16; i = i + 1) run({i[3:0], 4'h1}, 17'h0, 1'b0);
    run(8'h9D, 17'h1FFFF, 1'b0);
    run(8'hBD, 17'h10001, 1'b0);
    run(8'hBD, 17'h10000, 1'b0);
    run(8'h9D, 17'h0, 1'b1);
    run(8'hFF, 17'h0, 1'b0);
    repeat (4) @(negedge clock);
    results;
  end
  initial begin
    #100000;
    mismatches = mismatches + 1;
    results;
  end
endmodule // tb
`default_nettype wire

// ===== verif/wbo_exec_monitor.sv
// concurrent checks on the execution unit ports
// assumes a bind onto wbo_exec and a single clock domain
`timescale 1ns/10ps
`default_nettype none
module wbo_exec_monitor (
  input wire logic       clock,     // core clock
  input wire logic       nrst,      // reset, active low
  input wire logic       start,     // request
  input wire logic [7:0] opcode,    // opcode
  input wire logic [7:0] a_in,      // accumulator in
  input wire logic [7:0] y_in,      // y in
  input wire logic [7:0] psw_in,    // flags in
  input wire logic       busy,      // busy
  input wire logic       done,      // done pulse
  input wire logic [7:0] psw_out,   // flags out
  input wire logic       mem_rd,    // read strobe
  input wire logic       mem_wr,    // write strobe
  input wire logic [7:0] mem_wdata  // write data
);
  wire go = start && !busy;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // timing and memory walks
  // ----------------------------------------
  word_cycles_a : assert property (
    go && (opcode == 8'h1D || opcode == 8'h3D || opcode == 8'h7D) |-> ##5 done)
    else $error("word op not done at cycle 5");
  cmp_walk_a : assert property (
    go && opcode == 8'h5D |=> (!mem_wr)[*3] ##1 done)
    else $error("compare wrote memory or mistimed");
  rmw_walk_a : assert property (
    go && (opcode == 8'h9D || opcode == 8'hBD) |-> ##4 mem_wr ##1 mem_wr ##1 done)
    else $error("word step write-back mistimed");
  pair_store_a : assert property (
    go && opcode == 8'hDD |=> mem_wr && mem_wdata == $past(a_in)
    ##1 mem_wr && mem_wdata == $past(y_in, 2) ##3 done)
    else $error("pair store sequence wrong");
  carry_store_a : assert property (
    go && opcode == 8'hEB |-> ##3 mem_wr ##3 done)
    else $error("carry store mistimed");
  bit_test_a : assert property (
    go && opcode == 8'h0C |=> (!mem_wr)[*3] ##1 done)
    else $error("bit test wrote memory or mistimed");
  reg_only_a : assert property (
    go && (opcode == 8'h20 || opcode == 8'hA0 || opcode == 8'h2B || opcode == 8'h0B)
    |=> !mem_rd && !mem_wr ##1 done && !mem_wr)
    else $error("register op touched memory");
  // ----------------------------------------
  // flag forcing, busy span and done pulse
  // ----------------------------------------
  carry_force_a : assert property (
    go && (opcode == 8'h20 || opcode == 8'hA0)
    |-> ##2 psw_out[0] == ($past(opcode, 2) == 8'hA0))
    else $error("carry not forced");
  g_force_a : assert property (
    go && (opcode == 8'h40 || opcode == 8'hC0)
    |-> ##2 psw_out[5] == ($past(opcode, 2) == 8'hC0))
    else $error("g flag not forced");
  ovf_clear_a : assert property (
    go && opcode == 8'h80 |-> ##2 !psw_out[6] && psw_out[0] == $past(psw_in[0], 2))
    else $error("overflow not cleared alone");
  busy_span_a : assert property (
    go && opcode == 8'h9D |=> busy[*5] ##1 !busy)
    else $error("busy span wrong for word step");
  done_pulse_a : assert property (done |=> !done)
    else $error("done longer than one cycle");
endmodule // wbo_exec_monitor
bind wbo_exec wbo_exec_monitor u_mon (.clock(clock), .nrst(nrst), .start(start),
  .opcode(opcode), .a_in(a_in), .y_in(y_in), .psw_in(psw_in), .busy(busy), .done(done),
  .psw_out(psw_out), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata));
`default_nettype wire

// ===== verif/wbo_mem_model.sv
// data memory on the far side of the execution unit
// assumes read data due the cycle after mem_rd, write at the edge ending mem_wr
`timescale 1ns/10ps
`default_nettype none
module wbo_mem_model (
  input  wire logic        clock,     // core clock
  input  wire logic [15:0] mem_addr,  // address
  input  wire logic        mem_rd,    // read strobe
  input  wire logic        mem_wr,    // write strobe
  input  wire logic [7:0]  mem_wdata, // write data
  output var  logic [7:0]  mem_rdata  // read data
);
  logic [7:0] mem [0:65535];
  initial mem_rdata = 8'h00;
  // outside a read cycle the byte flips, so a sample one cycle late never matches; two cycles late it matches again
  always @(posedge clock) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
endmodule // wbo_mem_model
`default_nettype wire
